//--- verilog/bkrc_regs.sv
// Top: APB register bank for the two buck regulators' control settings
`timescale 1ns/100ps
module bkrc_regs
   import bkrc_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Fuse image
   input  wire logic                    fuseValid,
   input  wire logic                    fuseDischDis,
   input  wire logic [1:0]              fuseIlim,
   input  wire logic                    fuseTmode,
   input  wire logic [BKRC_VCODE_W-1:0] fuseRunCode,
   input  wire logic [BKRC_VCODE_W-1:0] fuseStbyCode,
   // Regulator state pins
   input  wire logic                    buck1Enabled,
   input  wire logic                    standbyMode,
   // Regulator controls
   output logic                         buck1DischargeConnect,
   output logic                         buck1DischargeDisable,
   output logic [1:0]                   buck1CurrentLimit,
   output logic                         buck1TimeControlSelect,
   output logic [BKRC_VCODE_W-1:0]      buck2VoltageCode,
   output logic [BKRC_VCODE_W-1:0]      buck2RunVoltageCode,
   output logic [BKRC_VCODE_W-1:0]      buck2StandbyVoltageCode
);
   bkrc_fuse_if fuse ();

   // Stored fields
   logic                    dischDis_q;
   bkrc_ilim_t              ilim_q;
   logic                    tmode_q;
   logic [BKRC_VCODE_W-1:0] runCode_q;
   logic [BKRC_VCODE_W-1:0] stbyCode_q;

   // Bus handshake state
   logic                    pready_q;
   logic                    pslverr_q;
   logic [31:0]             prdata_q;
   logic [31:0]             rdData_d;
   logic                    hit;
   logic                    access;
   logic                    wrFire;

   // Pin synchronisers
   logic                    enMeta_q;
   logic                    enSync_q;
   logic                    stbyMeta_q;
   logic                    stbySync_q;

   // Output flops
   logic                    dischConn_q;
   logic                    dischDisOut_q;
   logic [1:0]              ilimOut_q;
   logic                    tmodeOut_q;
   logic [BKRC_VCODE_W-1:0] voltOut_q;
   logic [BKRC_VCODE_W-1:0] runOut_q;
   logic [BKRC_VCODE_W-1:0] stbyOut_q;

   // Fuse image loader
   bkrc_fuse_load u_fuse_load (
      .mclk         (mclk),
      .rst_n        (rst_n),
      .fuseValid    (fuseValid),
      .fuseDischDis (fuseDischDis),
      .fuseIlim     (fuseIlim),
      .fuseTmode    (fuseTmode),
      .fuseRunCode  (fuseRunCode),
      .fuseStbyCode (fuseStbyCode),
      .fuse         (fuse.src)
   );

   // Address decode; only the four mapped words answer without error
   always_comb begin
      hit = (paddr == BKRC_ADDR_B1_CTRL) || (paddr == BKRC_ADDR_B1_LIMTM) ||
            (paddr == BKRC_ADDR_B2_RUN) || (paddr == BKRC_ADDR_B2_STBY);
   end

   // One wait state so every bus output can come from a flop
   assign access = psel && penable;
   assign wrFire = access && pready_q && pwrite && hit && pstrb[0];

   // Read mux; unused positions stay zero
   always_comb begin
      rdData_d = 32'h0000_0000;
      case (paddr)
         BKRC_ADDR_B1_CTRL:  rdData_d[BKRC_POS_DISCH] = dischDis_q;
         BKRC_ADDR_B1_LIMTM: begin
            rdData_d[BKRC_POS_ILIM_LO +: BKRC_ILIM_W] = ilim_q;
            rdData_d[BKRC_POS_TMODE]                  = tmode_q;
         end
         BKRC_ADDR_B2_RUN:   rdData_d[BKRC_POS_VCODE_LO +: BKRC_VCODE_W] = runCode_q;
         BKRC_ADDR_B2_STBY:  rdData_d[BKRC_POS_VCODE_LO +: BKRC_VCODE_W] = stbyCode_q;
         default:            rdData_d = 32'h0000_0000;
      endcase
   end

   // Ready, error and read data raised together, dropped after the taking edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (access && !pready_q) begin
         pready_q  <= 1'b1;
         pslverr_q <= !hit;
         prdata_q  <= (pwrite || !hit) ? 32'h0000_0000 : rdData_d;
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // First buck control word: discharge bit only in this bank
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dischDis_q <= BKRC_RST_DISCH;
      end else if (fuse.load) begin
         dischDis_q <= fuse.dischDis;
      end else if (wrFire && paddr == BKRC_ADDR_B1_CTRL) begin
         dischDis_q <= pwdata[BKRC_POS_DISCH];
      end
   end

   // Current limit; zero code until the fuse image says otherwise
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ilim_q <= bkrc_ilim_t'(BKRC_RST_ILIM);
      end else if (fuse.load) begin
         ilim_q <= fuse.ilim;
      end else if (wrFire && paddr == BKRC_ADDR_B1_LIMTM) begin
         ilim_q <= bkrc_ilim_t'(pwdata[BKRC_POS_ILIM_LO +: BKRC_ILIM_W]);
      end
   end

   // Timing-control select; plain software bit, not fuse loaded
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tmode_q <= BKRC_RST_TMODE;
      end else if (wrFire && paddr == BKRC_ADDR_B1_LIMTM) begin
         tmode_q <= pwdata[BKRC_POS_TMODE];
      end
   end

   // Second buck run code
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         runCode_q <= BKRC_RST_VCODE;
      end else if (fuse.load) begin
         runCode_q <= fuse.runCode;
      end else if (wrFire && paddr == BKRC_ADDR_B2_RUN) begin
         runCode_q <= pwdata[BKRC_POS_VCODE_LO +: BKRC_VCODE_W];
      end
   end

   // Second buck standby code; the fuse image carries the standby code here
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stbyCode_q <= BKRC_RST_VCODE;
      end else if (fuse.load) begin
         stbyCode_q <= fuse.stbyCode;
      end else if (wrFire && paddr == BKRC_ADDR_B2_STBY) begin
         stbyCode_q <= pwdata[BKRC_POS_VCODE_LO +: BKRC_VCODE_W];
      end
   end

   // Regulator state pins are asynchronous to mclk
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         enMeta_q   <= 1'b0;
         enSync_q   <= 1'b0;
         stbyMeta_q <= 1'b0;
         stbySync_q <= 1'b0;
      end else begin
         enMeta_q   <= buck1Enabled;
         enSync_q   <= enMeta_q;
         stbyMeta_q <= standbyMode;
         stbySync_q <= stbyMeta_q;
      end
   end

   // Discharge path: closed only while disabled and not suppressed by software
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dischConn_q <= 1'b0;
      end else begin
         dischConn_q <= !enSync_q && !dischDis_q;
      end
   end

   // Settings forwarded unchanged to the regulators
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dischDisOut_q <= BKRC_RST_DISCH;
         ilimOut_q     <= BKRC_RST_ILIM;
         tmodeOut_q    <= BKRC_RST_TMODE;
         runOut_q      <= BKRC_RST_VCODE;
         stbyOut_q     <= BKRC_RST_VCODE;
      end else begin
         dischDisOut_q <= dischDis_q;
         ilimOut_q     <= ilim_q;
         tmodeOut_q    <= tmode_q;
         runOut_q      <= runCode_q;
         stbyOut_q     <= stbyCode_q;
      end
   end

   // Active voltage code follows the operating mode
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         voltOut_q <= BKRC_RST_VCODE;
      end else begin
         voltOut_q <= stbySync_q ? stbyCode_q : runCode_q;
      end
   end

   assign buck1DischargeConnect   = dischConn_q;
   assign buck1DischargeDisable   = dischDisOut_q;
   assign buck1CurrentLimit       = ilimOut_q;
   assign buck1TimeControlSelect  = tmodeOut_q;
   assign buck2VoltageCode        = voltOut_q;
   assign buck2RunVoltageCode     = runOut_q;
   assign buck2StandbyVoltageCode = stbyOut_q;
endmodule

//--- verilog/bkrc_pkg.sv
// Package: register map, field layout and reset values of the buck control bank
package bkrc_pkg;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [7:0]  BKRC_IDX_B1_CTRL  = 8'h35;
   localparam logic [7:0]  BKRC_IDX_B1_LIMTM = 8'h36;
   localparam logic [7:0]  BKRC_IDX_B2_RUN   = 8'h38;
   localparam logic [7:0]  BKRC_IDX_B2_STBY  = 8'h39;
   localparam logic [11:0] BKRC_ADDR_B1_CTRL  = {2'h0, BKRC_IDX_B1_CTRL, 2'h0};
   localparam logic [11:0] BKRC_ADDR_B1_LIMTM = {2'h0, BKRC_IDX_B1_LIMTM, 2'h0};
   localparam logic [11:0] BKRC_ADDR_B2_RUN   = {2'h0, BKRC_IDX_B2_RUN, 2'h0};
   localparam logic [11:0] BKRC_ADDR_B2_STBY  = {2'h0, BKRC_IDX_B2_STBY, 2'h0};
   // Field positions
   localparam int BKRC_POS_DISCH     = 7;
   localparam int BKRC_POS_ILIM_LO   = 0;
   localparam int BKRC_POS_TMODE     = 4;
   localparam int BKRC_POS_VCODE_LO  = 0;
   localparam int BKRC_VCODE_W       = 6;
   localparam int BKRC_ILIM_W        = 2;
   // Reset values, held until the fuse image is loaded; the time select one until software writes it
   localparam logic                    BKRC_RST_DISCH = 1'h0;
   localparam logic [BKRC_ILIM_W-1:0]  BKRC_RST_ILIM  = 2'h0;
   localparam logic                    BKRC_RST_TMODE = 1'h0;
   localparam logic [BKRC_VCODE_W-1:0] BKRC_RST_VCODE = 6'h00;
   // Current-limit codes
   typedef enum logic [1:0] {
      BKRC_ILIM_1A0 = 2'b00,
      BKRC_ILIM_1A2 = 2'b01,
      BKRC_ILIM_1A5 = 2'b10,
      BKRC_ILIM_2A0 = 2'b11
   } bkrc_ilim_t;
   // Fuse loader states
   typedef enum logic [1:0] {
      BKRC_FL_WAIT = 2'b00,
      BKRC_FL_LOAD = 2'b01,
      BKRC_FL_DONE = 2'b10
   } bkrc_fl_state_t;
endpackage

//--- verilog/bkrc_fuse_if.sv
// Interface: fuse image handed from the loader to the register bank
`timescale 1ns/100ps
interface bkrc_fuse_if;
   import bkrc_pkg::*;
   logic                    load;
   logic                    dischDis;
   bkrc_ilim_t              ilim;
   logic                    tmode;
   logic [BKRC_VCODE_W-1:0] runCode;
   logic [BKRC_VCODE_W-1:0] stbyCode;
   modport src (output load, output dischDis, output ilim, output tmode,
                output runCode, output stbyCode);
   modport dst (input load, input dischDis, input ilim, input tmode,
                input runCode, input stbyCode);
endinterface

//--- verilog/bkrc_fuse_load.sv
// Fuse loader: synchronises the fuse image and hands it over once after start-up
`timescale 1ns/100ps
module bkrc_fuse_load
   import bkrc_pkg::*;
(
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire logic                    fuseValid,
   input  wire logic                    fuseDischDis,
   input  wire logic [1:0]              fuseIlim,
   input  wire logic                    fuseTmode,
   input  wire logic [BKRC_VCODE_W-1:0] fuseRunCode,
   input  wire logic [BKRC_VCODE_W-1:0] fuseStbyCode,
   bkrc_fuse_if.src                     fuse
);
   localparam int W = 2 + BKRC_ILIM_W + 2 * BKRC_VCODE_W;

   logic [W-1:0]   meta_q;
   logic [W-1:0]   sync_q;
   logic           validMeta_q;
   logic           validSync_q;
   bkrc_fl_state_t state_q;

   // Two-stage synchronisers; fuse bits come from another macro, not this clock
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_q      <= '0;
         sync_q      <= '0;
         validMeta_q <= 1'b0;
         validSync_q <= 1'b0;
      end else begin
         meta_q      <= {fuseDischDis, fuseIlim, fuseTmode, fuseRunCode, fuseStbyCode};
         sync_q      <= meta_q;
         validMeta_q <= fuseValid;
         validSync_q <= validMeta_q;
      end
   end

   // One load per reset; data stages settle together with the valid stage
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= BKRC_FL_WAIT;
      end else begin
         case (state_q)
            BKRC_FL_WAIT: begin
               if (validSync_q) begin
                  state_q <= BKRC_FL_LOAD;
               end
            end
            BKRC_FL_LOAD: state_q <= BKRC_FL_DONE;
            BKRC_FL_DONE: state_q <= BKRC_FL_DONE;
            default:      state_q <= BKRC_FL_WAIT;
         endcase
      end
   end

   // Image fields to the bank
   assign fuse.load     = (state_q == BKRC_FL_LOAD);
   assign fuse.dischDis = sync_q[W-1];
   assign fuse.ilim     = bkrc_ilim_t'(sync_q[W-2 -: BKRC_ILIM_W]);
   assign fuse.tmode    = sync_q[2*BKRC_VCODE_W];
   assign fuse.runCode  = sync_q[2*BKRC_VCODE_W-1 -: BKRC_VCODE_W];
   assign fuse.stbyCode = sync_q[BKRC_VCODE_W-1:0];
endmodule

//--- tb/bkrc_regs_props.sv
// Checker: APB answer and forwarded regulator controls of the buck control bank
`timescale 1ns/100ps
module bkrc_regs_props
   import bkrc_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        buck1Enabled,
   input wire logic        standbyMode,
   input wire logic        buck1DischargeConnect,
   input wire logic        buck1DischargeDisable,
   input wire logic [1:0]  buck1CurrentLimit,
   input wire logic        buck1TimeControlSelect,
   input wire logic [5:0]  buck2VoltageCode,
   input wire logic [5:0]  buck2RunVoltageCode,
   input wire logic [5:0]  buck2StandbyVoltageCode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Readable bits of each register, zero where unmapped
   function automatic logic [31:0] rmask(logic [11:0] a);
      case (a)
         BKRC_ADDR_B1_CTRL:  return 32'h80;
         BKRC_ADDR_B1_LIMTM: return 32'h13;
         BKRC_ADDR_B2_RUN:   return 32'h3F;
         BKRC_ADDR_B2_STBY:  return 32'h3F;
         default:            return 32'h0;
      endcase
   endfunction
   // Completed write with the low byte enabled
   sequence s_wr(logic [11:0] a);
      psel && penable && pready && pwrite && pstrb[0] && !pslverr && paddr == a;
   endsequence
   // Pins held long enough to pass the input synchronisers
   sequence s_off_low;
      !buck1Enabled && !buck1DischargeDisable;
   endsequence
   sequence s_stby;
      standbyMode && $stable(buck2StandbyVoltageCode);
   endsequence
   sequence s_run;
      !standbyMode && $stable(buck2RunVoltageCode);
   endsequence
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after one wait state");
   a_ready_in_access: assert property (pready |-> psel && penable && !$past(pready))
      else $error("pready outside a single access");
   a_err_unmapped: assert property (pready |-> pslverr == (rmask(paddr) == 32'h0))
      else $error("pslverr does not match address map");
   a_read_unused: assert property (pready && !pwrite |->
      (prdata & ~rmask(paddr)) == 32'h0) else $error("unused bits read nonzero");
   a_disch_on: assert property (s_off_low [*5] |-> buck1DischargeConnect)
      else $error("discharge resistor not connected");
   a_disch_off: assert property (buck1DischargeDisable && $past(buck1DischargeDisable)
      |-> !buck1DischargeConnect) else $error("discharge connected while disabled");
   a_disch_en: assert property (buck1Enabled [*5] |-> !buck1DischargeConnect)
      else $error("discharge connected while buck enabled");
   a_stby_sel: assert property (s_stby [*5] |->
      buck2VoltageCode == buck2StandbyVoltageCode)
      else $error("standby code not used in standby");
   a_run_sel: assert property (s_run [*5] |->
      buck2VoltageCode == buck2RunVoltageCode)
      else $error("run code not used in run mode");
   a_lim_fwd: assert property (s_wr(BKRC_ADDR_B1_LIMTM) |=> ##1
      ($past(pwdata, 2) & 32'h13) == {27'h0, buck1TimeControlSelect, 2'h0, buck1CurrentLimit})
      else $error("limit or time select not forwarded");
   a_run_fwd: assert property (s_wr(BKRC_ADDR_B2_RUN) |=> ##1
      ($past(pwdata, 2) & 32'h3F) == {26'h0, buck2RunVoltageCode})
      else $error("run code not forwarded");
endmodule
bind bkrc_regs bkrc_regs_props u_props (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pready, .prdata, .pslverr, .buck1Enabled, .standbyMode,
   .buck1DischargeConnect, .buck1DischargeDisable, .buck1CurrentLimit, .buck1TimeControlSelect,
   .buck2VoltageCode, .buck2RunVoltageCode, .buck2StandbyVoltageCode);

//--- tb/bkrc_regs_test.sv
// Testbench: APB register sequences against the buck control bank
`timescale 1ns/100ps
module bkrc_regs_test;
   import bkrc_pkg::*;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic        fuseValid, fuseDischDis, fuseTmode, buck1Enabled, standbyMode;
   logic        buck1DischargeConnect, buck1DischargeDisable, buck1TimeControlSelect;
   logic [1:0]  fuseIlim, buck1CurrentLimit, code;
   logic [3:0]  pstrb;
   logic [5:0]  fuseRunCode, fuseStbyCode, v;
   logic [5:0]  buck2VoltageCode, buck2RunVoltageCode, buck2StandbyVoltageCode;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          num_errors, tests_run;
   bkrc_regs dut_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .fuseValid, .fuseDischDis, .fuseIlim, .fuseTmode, .fuseRunCode,
      .fuseStbyCode, .buck1Enabled, .standbyMode, .buck1DischargeConnect,
      .buck1DischargeDisable, .buck1CurrentLimit, .buck1TimeControlSelect,
      .buck2VoltageCode, .buck2RunVoltageCode, .buck2StandbyVoltageCode);
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task finish_test;
      $display("Mismatches %0d of %0d comparisons", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // One APB transfer; request held until pready is seen at a rising edge
   // No cycle count is assumed here; only the watchdog ends a wait that never completes
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'hF);
      check(what, rd, exp);
      check("read error flag", {31'h0, er}, 32'h0);
   endtask
   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #250000;
      num_errors++;
      finish_test();
   end
   initial begin
      num_errors = 0; tests_run = 0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; pstrb = 4'h0; fuseValid = 1'b0;
      fuseDischDis = 1'b1; fuseIlim = 2'h2; fuseTmode = 1'b1; fuseRunCode = 6'h2A;
      fuseStbyCode = 6'h2A; buck1Enabled = 1'b1; standbyMode = 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      // Values before the fuse image arrives
      rdc("ctrl reset", BKRC_ADDR_B1_CTRL, 32'h0);
      rdc("limit reset", BKRC_ADDR_B1_LIMTM, 32'h0);
      rdc("run reset", BKRC_ADDR_B2_RUN, 32'h0);
      fuseValid <= 1'b1;
      cyc(8);
      // Fuse image loaded; time select is not taken from it
      rdc("ctrl fuse", BKRC_ADDR_B1_CTRL, 32'h80);
      rdc("limit fuse", BKRC_ADDR_B1_LIMTM, 32'h02);
      rdc("run fuse", BKRC_ADDR_B2_RUN, 32'h2A);
      rdc("stby fuse", BKRC_ADDR_B2_STBY, 32'h2A);
      // Every limit code, time select toggling, junk in unused bits
      for (int i = 0; i < 4; i++) begin
         code = i[1:0];
         wr(BKRC_ADDR_B1_LIMTM, 32'hFFFFFFEC | i | (i << 4));
         cyc(2);
         check("limit out", {30'h0, buck1CurrentLimit}, {30'h0, code});
         check("tsel out", {31'h0, buck1TimeControlSelect}, {31'h0, code[0]});
         rdc("limit read", BKRC_ADDR_B1_LIMTM, {27'h0, code[0], 2'h0, code});
      end
      // Voltage code boundaries, run and standby selection
      for (int j = 0; j < 2; j++) begin
         v = j ? 6'h3F : 6'h00;
         wr(BKRC_ADDR_B2_RUN, {26'h3FFFFFF, v});
         wr(BKRC_ADDR_B2_STBY, {26'h3FFFFFF, ~v});
         rdc("run read", BKRC_ADDR_B2_RUN, {26'h0, v});
         rdc("stby read", BKRC_ADDR_B2_STBY, {26'h0, ~v});
         standbyMode <= 1'b0;
         cyc(5);
         check("run select", {26'h0, buck2VoltageCode}, {26'h0, v});
         check("run out", {26'h0, buck2RunVoltageCode}, {26'h0, v});
         standbyMode <= 1'b1;
         cyc(5);
         check("stby select", {26'h0, buck2VoltageCode}, {26'h0, ~v});
         check("stby out", {26'h0, buck2StandbyVoltageCode}, {26'h0, ~v});
      end
      // Discharge resistor against the control bit and the enable pin
      wr(BKRC_ADDR_B1_CTRL, 32'hFFFFFF7F);
      rdc("ctrl read", BKRC_ADDR_B1_CTRL, 32'h0);
      buck1Enabled <= 1'b0;
      cyc(5);
      check("disch on", {31'h0, buck1DischargeConnect}, 32'h1);
      wr(BKRC_ADDR_B1_CTRL, 32'h80);
      cyc(2);
      check("disch off", {31'h0, buck1DischargeConnect}, 32'h0);
      check("disch bit out", {31'h0, buck1DischargeDisable}, 32'h1);
      wr(BKRC_ADDR_B1_CTRL, 32'h0);
      buck1Enabled <= 1'b1;
      cyc(5);
      check("disch enabled", {31'h0, buck1DischargeConnect}, 32'h0);
      // Refused accesses leave the registers alone
      apb(1'b1, BKRC_ADDR_B2_RUN, 32'h15, 4'h0);
      rdc("strobe off", BKRC_ADDR_B2_RUN, 32'h3F);
      apb(1'b1, 12'hDC, 32'hFF, 4'hF);
      check("unmapped wr err", {31'h0, er}, 32'h1);
      apb(1'b0, 12'hD0, 32'h0, 4'hF);
      check("unmapped rd err", {31'h0, er}, 32'h1);
      check("unmapped rd data", rd, 32'h0);
      finish_test();
   end
endmodule
